// [hw/nlc_consts.svh]
`ifndef NLC_CONSTS_SVH
`define NLC_CONSTS_SVH
`define NLC_OFF_LINK_CTL    8'h00
`define NLC_OFF_LED_PHY     8'h1c
`define NLC_OFF_STATUS      8'h04
`define NLC_OFF_EFFECT      8'h08
`define NLC_LINK_CTL_DFLT   16'h4600
`define NLC_LED_PHY_DFLT    16'h2d84
`define NLC_LED_PHY_RSVD_M  16'h0010
`define NLC_B_L2_BLOCK      5
`define NLC_B_VEC_LO        7
`define NLC_B_LEAKY_OFF     10
`define NLC_B_GOOD_RECOV    11
`define NLC_B_LEGACY_FSM    12
`define NLC_B_NO_DOWN_RST   13
`define NLC_B_L1_MSB        14
`define NLC_B_FORCE_RX      15
`define NLC_B_SRC_LO        0
`define NLC_B_FAST_BLINK    5
`define NLC_B_POLARITY      6
`define NLC_B_FLASH_EN      7
`define NLC_B_D0A_REDUCE    9
`define NLC_B_LP_REDUCE     10
`define NLC_B_NO_GIG_LP     11
`define NLC_B_CLASS_A       12
`define NLC_B_GIG_OFF       14
`define NLC_VEC_MAX         3'h4
`define NLC_CLK_HZ          40000000
`define NLC_BLINK_SLOW_MS   200
`define NLC_BLINK_FAST_MS   83
`define NLC_SLOW_CYC  ((`NLC_CLK_HZ/1000)*`NLC_BLINK_SLOW_MS)
`define NLC_FAST_CYC  ((`NLC_CLK_HZ/1000)*`NLC_BLINK_FAST_MS)
`endif

// [hw/nlc_pkg.sv]
package nlc_pkg;
   typedef enum logic [1:0] {NLC_WAIT, NLC_LOAD, NLC_RUN} nlc_state_t;
endpackage

// [hw/nlc_top.sv]
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "nlc_consts.svh"
module nlc_top
   import nlc_pkg::*;
#(
   parameter int unsigned SLOW_CYC = `NLC_SLOW_CYC,
   parameter int unsigned FAST_CYC = `NLC_FAST_CYC
)(
   input  wire logic        REF_CLK,
   input  wire logic        RSTN,
   input  wire logic        CLK_EN,
   input  wire logic        NVM_DONE,
   input  wire logic        NVM_VALID,
   input  wire logic [15:0] NVM_LINK_CTL,
   input  wire logic [15:0] NVM_LED_PHY,
   input  wire logic        IN_D0A,
   input  wire logic        POLICY_REDUCE,
   input  wire logic        LINK_DOWN,
   input  wire logic        RX_DETECTED,
   input  wire logic        ACTIVITY,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             CFG_READY,
   output logic             L2_BLOCK,
   output logic [2:0]       VEC_TABLE_SIZE_M1,
   output logic             LEAKY_BUCKET_OFF,
   output logic             FORCE_GOOD_RECOVERY,
   output logic             LEGACY_TRAINING_FSM,
   output logic [2:0]       L1_ENTRY_DELAY_MSB,
   output logic             CORE_RESET_REQ,
   output logic             RX_PRESENT,
   output logic [3:0]       ACT_LED_SOURCE,
   output logic             ACT_LED,
   output logic             SPEED_REDUCE,
   output logic             GIG_ALLOWED,
   output logic             GIG_CLASS_A
);
   nlc_state_t  state_r;
   logic [15:0] link_r;
   logic [15:0] led_r;
   logic [1:0]  sync_done_r;
   logic [2:0]  sync_down_r;
   logic [1:0]  sync_rx_r;
   logic [1:0]  sync_act_r;
   logic [1:0]  sync_d0a_r;
   logic [1:0]  sync_pol_r;
   logic [31:0] blink_cnt_r;
   logic        blink_ph_r;
   logic        rd_ack_r;
   logic [31:0] rdata_r;
   logic        img_bad_r;

   wire done_s  = sync_done_r[1];
   wire down_s  = sync_down_r[1];
   wire down_rise = sync_down_r[1] & ~sync_down_r[2];

   // Clamp a vector count that asks for more than five entries
   function automatic logic [2:0] vec_clamp(input logic [2:0] v);
      vec_clamp = (v > `NLC_VEC_MAX) ? `NLC_VEC_MAX : v;
   endfunction

   wire        led_wr  = AVS_WRITE & (AVS_ADDRESS == `NLC_OFF_LED_PHY);
   wire        link_wr = AVS_WRITE & (AVS_ADDRESS == `NLC_OFF_LINK_CTL);
   wire [15:0] wmask   = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   wire [15:0] led_w   = ((led_r & ~wmask) | (AVS_WRITEDATA[15:0] & wmask))
                         & ~`NLC_LED_PHY_RSVD_M;
   wire [15:0] link_w  = (link_r & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
   wire [15:0] img_led = NVM_LED_PHY & ~`NLC_LED_PHY_RSVD_M;

   wire [31:0] blink_lim = led_r[`NLC_B_FAST_BLINK] ?
                           (FAST_CYC - 1) : (SLOW_CYC - 1);
   wire        flash_en  = led_r[`NLC_B_FLASH_EN];
   wire        led_on    = sync_act_r[1] & (~flash_en | blink_ph_r);

   wire gig_ok = ~led_r[`NLC_B_GIG_OFF]
               & (sync_d0a_r[1] | ~led_r[`NLC_B_NO_GIG_LP]);
   wire reduce = sync_pol_r[1] & (sync_d0a_r[1] ?
                 led_r[`NLC_B_D0A_REDUCE] :
                 led_r[`NLC_B_LP_REDUCE]);

   wire [31:0] status_w = {29'h0, img_bad_r, down_s, state_r == NLC_RUN};
   wire [31:0] effect_w = {26'h0, gig_ok, reduce, ACT_LED, RX_PRESENT,
                           CORE_RESET_REQ, L2_BLOCK};
   wire [31:0] rd_mux =
        (AVS_ADDRESS == `NLC_OFF_LINK_CTL) ? {16'h0, link_r} :
        (AVS_ADDRESS == `NLC_OFF_LED_PHY)  ? {16'h0, led_r}  :
        (AVS_ADDRESS == `NLC_OFF_STATUS)   ? status_w        :
        (AVS_ADDRESS == `NLC_OFF_EFFECT)   ? effect_w        : 32'h0;

   // Reads take one wait cycle so that read data always come from a flop
   assign AVS_WAITREQUEST = AVS_READ & ~rd_ack_r;
   assign AVS_READDATA    = rdata_r;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync_done_r <= 2'h0;
         sync_down_r <= 3'h0;
         sync_rx_r   <= 2'h0;
         sync_act_r  <= 2'h0;
         sync_d0a_r  <= 2'h0;
         sync_pol_r  <= 2'h0;
      end else if (CLK_EN) begin
         sync_done_r <= {sync_done_r[0], NVM_DONE};
         sync_down_r <= {sync_down_r[1:0], LINK_DOWN};
         sync_rx_r   <= {sync_rx_r[0], RX_DETECTED};
         sync_act_r  <= {sync_act_r[0], ACTIVITY};
         sync_d0a_r  <= {sync_d0a_r[0], IN_D0A};
         sync_pol_r  <= {sync_pol_r[0], POLICY_REDUCE};
      end
   end

   // Valid image words are sampled once the loader reports done; until then
   // the hardware defaults stand
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r   <= NLC_WAIT;
         link_r    <= `NLC_LINK_CTL_DFLT;
         led_r     <= `NLC_LED_PHY_DFLT;
         img_bad_r <= 1'b0;
      end else if (CLK_EN) begin
         unique case (state_r)
            NLC_WAIT: if (done_s) state_r <= NLC_LOAD;
            NLC_LOAD: begin
               if (NVM_VALID) begin
                  link_r <= NVM_LINK_CTL;
                  led_r  <= img_led;
               end
               img_bad_r <= ~NVM_VALID;
               state_r   <= NLC_RUN;
            end
            NLC_RUN: begin
               if (link_wr) link_r <= link_w;
               if (led_wr)  led_r  <= led_w;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rd_ack_r <= 1'b0;
         rdata_r  <= 32'h0;
      end else if (CLK_EN) begin
         rd_ack_r <= AVS_READ & ~rd_ack_r;
         if (AVS_READ & ~rd_ack_r) rdata_r <= rd_mux;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         blink_cnt_r <= 32'h0;
         blink_ph_r  <= 1'b1;
      end else if (CLK_EN) begin
         if (!flash_en) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r  <= 1'b1;
         end else if (blink_cnt_r >= blink_lim) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r  <= ~blink_ph_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
         end
      end
   end

   // Outputs are registered; core reset is a one-cycle pulse per link loss
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         CFG_READY           <= 1'b0;
         L2_BLOCK            <= 1'b0;
         VEC_TABLE_SIZE_M1   <= `NLC_VEC_MAX;
         LEAKY_BUCKET_OFF    <= 1'b1;
         FORCE_GOOD_RECOVERY <= 1'b0;
         LEGACY_TRAINING_FSM <= 1'b0;
         L1_ENTRY_DELAY_MSB  <= 3'h4;
         CORE_RESET_REQ      <= 1'b0;
         RX_PRESENT          <= 1'b0;
         ACT_LED_SOURCE      <= 4'h4;
         ACT_LED             <= 1'b1;
         SPEED_REDUCE        <= 1'b0;
         GIG_ALLOWED         <= 1'b0;
         GIG_CLASS_A         <= 1'b0;
      end else if (CLK_EN) begin
         CFG_READY           <= (state_r == NLC_RUN);
         L2_BLOCK            <= link_r[`NLC_B_L2_BLOCK];
         VEC_TABLE_SIZE_M1   <=
            vec_clamp(link_r[`NLC_B_VEC_LO +: 3]);
         LEAKY_BUCKET_OFF    <= link_r[`NLC_B_LEAKY_OFF];
         FORCE_GOOD_RECOVERY <= link_r[`NLC_B_GOOD_RECOV];
         LEGACY_TRAINING_FSM <= link_r[`NLC_B_LEGACY_FSM];
         L1_ENTRY_DELAY_MSB  <= {link_r[`NLC_B_L1_MSB], 2'h0};
         CORE_RESET_REQ      <= down_rise &
                                ~link_r[`NLC_B_NO_DOWN_RST];
         RX_PRESENT          <= link_r[`NLC_B_FORCE_RX] |
                                sync_rx_r[1];
         ACT_LED_SOURCE      <= led_r[`NLC_B_SRC_LO +: 4];
         ACT_LED             <= led_r[`NLC_B_POLARITY] ?
                                led_on : ~led_on;
         SPEED_REDUCE        <= reduce;
         GIG_ALLOWED         <= gig_ok;
         GIG_CLASS_A         <= led_r[`NLC_B_CLASS_A] & gig_ok;
      end
   end
endmodule // nlc_top

// [verif/nlc_checker.sv]
`timescale 1ns/1ps
module nlc_checker (
   input wire logic       REF_CLK,
   input wire logic       RSTN,
   input wire logic       AVS_READ,
   input wire logic       AVS_WRITE,
   input wire logic       AVS_WAITREQUEST,
   input wire logic       CFG_READY,
   input wire logic [2:0] VEC_TABLE_SIZE_M1,
   input wire logic [2:0] L1_ENTRY_DELAY_MSB,
   input wire logic       LEAKY_BUCKET_OFF,
   input wire logic [3:0] ACT_LED_SOURCE,
   input wire logic       GIG_CLASS_A,
   input wire logic       GIG_ALLOWED,
   input wire logic       CORE_RESET_REQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   AST_RD_ONE:
      assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("read answer late");
   AST_WR_NOWAIT:
      assert property (AVS_WRITE |-> !AVS_WAITREQUEST) else $error("write stalled");
   AST_DFLT:
      assert property (!CFG_READY |-> VEC_TABLE_SIZE_M1 == 3'h4 && LEAKY_BUCKET_OFF
         && L1_ENTRY_DELAY_MSB == 3'h4 && ACT_LED_SOURCE == 4'h4)
      else $error("defaults lost before load");
   AST_READY_HOLD:
      assert property (CFG_READY |=> CFG_READY) else $error("ready dropped");
   AST_VEC_MAX:
      assert property (VEC_TABLE_SIZE_M1 <= 3'h4) else $error("vector size over five");
   AST_L1_LOW:
      assert property (L1_ENTRY_DELAY_MSB[1:0] == 2'h0) else $error("L1 low bits set");
   AST_CLASS_A:
      assert property (GIG_CLASS_A |-> GIG_ALLOWED) else $error("class A without gig");
   AST_CORE_PULSE:
      assert property (CORE_RESET_REQ |=> !CORE_RESET_REQ) else $error("reset pulse long");
   cover property ($rose(CFG_READY));
   cover property (CORE_RESET_REQ);
   cover property (GIG_CLASS_A);
endmodule // nlc_checker
bind nlc_top nlc_checker i_nlc_checker (.REF_CLK, .RSTN, .AVS_READ, .AVS_WRITE,
   .AVS_WAITREQUEST, .CFG_READY, .VEC_TABLE_SIZE_M1, .L1_ENTRY_DELAY_MSB,
   .LEAKY_BUCKET_OFF, .ACT_LED_SOURCE, .GIG_CLASS_A, .GIG_ALLOWED, .CORE_RESET_REQ);

// [verif/nlc_nvm_model.sv]
`timescale 1ns/1ps
module nlc_nvm_model (
   input  wire logic        REF_CLK,
   input  wire logic        go,
   input  wire logic        ok,
   input  wire logic [15:0] link,
   input  wire logic [15:0] led,
   output logic             NVM_DONE,
   output logic             NVM_VALID,
   output logic [15:0]      NVM_LINK_CTL,
   output logic [15:0]      NVM_LED_PHY
);
   // Until the load ends the lines hold no image, so show its inverse
   always_ff @(posedge REF_CLK) begin
      NVM_DONE     <= go;
      NVM_VALID    <= go ? ok : ~ok;
      NVM_LINK_CTL <= go ? link : ~link;
      NVM_LED_PHY  <= go ? (led & 16'hffef) : ~led;
   end
endmodule // nlc_nvm_model

// [verif/nlc_top_bench.sv]
`timescale 1ns/1ps
module nlc_top_bench;
   logic        REF_CLK, RSTN, CLK_EN, NVM_DONE, NVM_VALID, IN_D0A, img_go;
   logic        POLICY_REDUCE, LINK_DOWN, RX_DETECTED, ACTIVITY, img_ok;
   logic        AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CFG_READY, L2_BLOCK;
   logic        LEAKY_BUCKET_OFF, FORCE_GOOD_RECOVERY, LEGACY_TRAINING_FSM;
   logic        CORE_RESET_REQ, RX_PRESENT, ACT_LED, SPEED_REDUCE;
   logic        GIG_ALLOWED, GIG_CLASS_A;
   logic [15:0] NVM_LINK_CTL, NVM_LED_PHY, img_link, img_led, w;
   logic [7:0]  AVS_ADDRESS;
   logic [31:0] AVS_READDATA, AVS_WRITEDATA, q;
   logic [3:0]  AVS_BYTEENABLE, ACT_LED_SOURCE;
   logic [2:0]  VEC_TABLE_SIZE_M1, L1_ENTRY_DELAY_MSB;
   logic [2:0]  exp;
   int          n_fail = 0;
   int          n_compared = 0;
   nlc_top #(.SLOW_CYC(20), .FAST_CYC(8)) i_nlc_top (.REF_CLK, .RSTN, .CLK_EN,
      .NVM_DONE, .NVM_VALID, .NVM_LINK_CTL, .NVM_LED_PHY, .IN_D0A, .POLICY_REDUCE,
      .LINK_DOWN, .RX_DETECTED, .ACTIVITY, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
      .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CFG_READY,
      .L2_BLOCK, .VEC_TABLE_SIZE_M1, .LEAKY_BUCKET_OFF, .FORCE_GOOD_RECOVERY,
      .LEGACY_TRAINING_FSM, .L1_ENTRY_DELAY_MSB, .CORE_RESET_REQ, .RX_PRESENT,
      .ACT_LED_SOURCE, .ACT_LED, .SPEED_REDUCE, .GIG_ALLOWED, .GIG_CLASS_A);
   nlc_nvm_model i_nlc_nvm_model (.REF_CLK, .go(img_go), .ok(img_ok),
      .link(img_link), .led(img_led), .NVM_DONE, .NVM_VALID, .NVM_LINK_CTL,
      .NVM_LED_PHY);
   initial begin
      REF_CLK = 0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end
   task stop_test;
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Request holds until the rising edge that sees waitrequest low;
   // data is taken and the request released at that same edge
   task bus(input logic rd, input logic [7:0] a, input logic [15:0] d);
      int k;
      @(posedge REF_CLK);
      AVS_ADDRESS <= a; AVS_READ <= rd; AVS_WRITE <= !rd;
      AVS_WRITEDATA <= {16'h0000, d};
      k = 0;
      do begin @(posedge REF_CLK); k++; end
      while (AVS_WAITREQUEST !== 1'b0 && k < 20);
      if (AVS_WAITREQUEST !== 1'b0) begin n_fail++; stop_test; end
      q = AVS_READDATA;
      AVS_READ <= 0; AVS_WRITE <= 0;
   endtask
   task reset;
      @(posedge REF_CLK); RSTN <= 0; img_go <= 0;
      repeat (2) @(posedge REF_CLK);
      RSTN <= 1;
      @(posedge REF_CLK);
   endtask
   task load(input logic ok);
      int k;
      img_ok <= ok; img_go <= 1;
      for (k = 0; k < 50 && CFG_READY !== 1'b1; k++) @(negedge REF_CLK);
      if (CFG_READY !== 1'b1) begin n_fail++; stop_test; end
      repeat (3) @(posedge REF_CLK);
   endtask
   task t_defaults;
      reset;
      chk({CFG_READY, L2_BLOCK, VEC_TABLE_SIZE_M1, LEAKY_BUCKET_OFF, L1_ENTRY_DELAY_MSB,
         ACT_LED_SOURCE, ACT_LED}, {2'b00, 3'h4, 1'b1, 3'h4, 4'h4, 1'b1});
      bus(0, 8'h00, 16'h0000);
      bus(1, 8'h00, 16'h0000); chk(q, 32'h4600);
      bus(1, 8'h1c, 16'h0000); chk(q, 32'h2d84);
      load(0);
      bus(1, 8'h00, 16'h0000); chk(q, 32'h4600);
   endtask
   task pulses(input int e);
      int n, k;
      @(posedge REF_CLK); LINK_DOWN <= 1; n = 0;
      for (k = 0; k < 8; k++) begin @(negedge REF_CLK); n += (CORE_RESET_REQ === 1'b1); end
      chk(n, e);
      LINK_DOWN <= 0; repeat (4) @(posedge REF_CLK);
   endtask
   task t_image;
      img_link <= 16'hbfa0; img_led <= 16'h50f3; reset; load(1);
      chk({L2_BLOCK, VEC_TABLE_SIZE_M1, LEAKY_BUCKET_OFF, FORCE_GOOD_RECOVERY,
         LEGACY_TRAINING_FSM, L1_ENTRY_DELAY_MSB, RX_PRESENT, ACT_LED_SOURCE, GIG_ALLOWED,
         GIG_CLASS_A}, {1'b1, 3'h4, 3'b111, 3'h0, 1'b1, 4'h3, 2'b00});
      bus(1, 8'h1c, 16'h0000); chk(q, 32'h50e3);
      pulses(0);
      bus(0, 8'h00, 16'h0000); repeat (3) @(posedge REF_CLK);
      chk({L2_BLOCK, RX_PRESENT, LEAKY_BUCKET_OFF}, 3'b000);
      pulses(1);
      RX_DETECTED <= 1; repeat (5) @(posedge REF_CLK); chk(RX_PRESENT, 1);
      bus(1, 8'h40, 16'h0000); chk(q, 32'h0);
   endtask
   task t_speed;
      logic [15:0] tbl [4];
      tbl = '{16'h0e00, 16'h4000, 16'h1000, 16'h0600};
      for (int i = 0; i < 16; i++) begin
         w = tbl[i[3:2]];
         IN_D0A <= i[0]; POLICY_REDUCE <= i[1];
         bus(0, 8'h1c, w); repeat (5) @(posedge REF_CLK);
         exp[1] = !w[14] && (i[0] || !w[11]);
         exp[2] = w[12] && exp[1];
         exp[0] = i[1] && (i[0] ? w[9] : w[10]);
         chk({GIG_CLASS_A, GIG_ALLOWED, SPEED_REDUCE}, exp);
      end
   endtask
   task per(input logic [15:0] d, input int e);
      int c;
      logic v;
      bus(0, 8'h1c, d); repeat (4) @(posedge REF_CLK);
      for (int j = 0; j < 2; j++) begin
         v = ACT_LED; c = 0;
         while (ACT_LED === v && c < 60) begin @(negedge REF_CLK); c++; end
      end
      chk(c, e);
   endtask
   task t_blink;
      ACTIVITY <= 1;
      per(16'h00e3, 8);
      per(16'h00c3, 20);
      per(16'h0043, 60);
      chk(ACT_LED, 1);
      bus(0, 8'h1c, 16'h0003); repeat (4) @(posedge REF_CLK); chk(ACT_LED, 0);
      ACTIVITY <= 0; repeat (5) @(posedge REF_CLK); chk(ACT_LED, 1);
   endtask
   initial begin
      RSTN = 0; CLK_EN = 1; IN_D0A = 0; POLICY_REDUCE = 0; LINK_DOWN = 0;
      RX_DETECTED = 0; ACTIVITY = 0; AVS_ADDRESS = 0; AVS_READ = 0; AVS_WRITE = 0;
      AVS_WRITEDATA = 0; AVS_BYTEENABLE = 4'h3; img_go = 0; img_ok = 0;
      img_link = 16'h0000; img_led = 16'h0000;
      t_defaults;
      t_image;
      t_speed;
      t_blink;
      stop_test;
   end
endmodule // nlc_top_bench
